// *** mars_consts.svh ***
// Purpose: Timing constants for the mirror array rail sequencer.
// Assumes: The sequencer clock runs at 25 MHz, a period of 40 ns.
// Notes:   Times keep their printed figures; cycle counts derive from them.
`ifndef MARS_CONSTS_SVH
`define MARS_CONSTS_SVH

// ****************************************************************
// Clock and times
// ****************************************************************
// Clock period in nanoseconds.
`define MARS_CLK_PERIOD_NS 40
// Deglitch filter time on the power request input, in microseconds.
`define MARS_DEGLITCH_US 1000
// Delay from array initialisation to offset rail enable, in microseconds.
`define MARS_OFS_DELAY_US 5000
// Delay from offset rail to bias and reset rails, in microseconds.
`define MARS_BIAS_DELAY_US 145000
// Delay between steps of the ordered power-down, in microseconds.
`define MARS_DOWN_STEP_US 5000
// Cycles per microsecond at the clock rate above.
`define MARS_CYC_PER_US (1000 / `MARS_CLK_PERIOD_NS)
// Width of the shared delay counter.
`define MARS_CNT_W 32
// Width of the deglitch counter.
`define MARS_DGL_W 16

`endif

// *** mars_pkg.sv ***
// Purpose: Types shared by the mirror array rail sequencer.
// Assumes: Nothing beyond the constants header.
// Notes:   States are one-hot with their codes written out.
package mars_pkg;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  // One-hot sequencer states.
  typedef enum logic [6:0]
  {
    MARS_OFF     = 7'h01,
    MARS_INIT    = 7'h02,
    MARS_OFS_ON  = 7'h04,
    MARS_ALL_ON  = 7'h08,
    MARS_DN_LOAD = 7'h10,
    MARS_DN_RAIL = 7'h20,
    MARS_FAULT   = 7'h40
  } mars_state_type;

  // Enables for the three rails travel together.
  typedef struct packed
  {
    logic offset_rail;
    logic bias_rail;
    logic array_reset_rail;
  } mars_rails_type;

endpackage : mars_pkg

// *** mars_sequencer.sv ***
// Purpose: Power sequencer for the offset, bias and reset rails of a
//          micromirror array, with load release and fault shutdown.
// Assumes: Fault inputs and the power request come from outside the
//          clock domain and are synchronised here.
// Notes:   Long delays are module parameters so that a simulation can
//          shorten them.
// Functional notes
// [RQ1] Request high: init array, then enable offset.
// [RQ2] Bias and reset rails 145 ms after offset.
// [RQ3] LED and strobe enabled only after rails.
// [RQ4] Request low: ordered rail power-down.
// [RQ5] Any rail fault: discharge all rails together.
// [RQ6] Deglitch power request for about 1 ms.
// [RQ7] Fault pulls interrupt low unless masked.
// [RQ8] Request drop mid power-up: ordered power-down.
`include "mars_consts.svh"

module mars_sequencer
  import mars_pkg::*;
#(
  parameter int unsigned DGL_CYC  = `MARS_DEGLITCH_US * `MARS_CYC_PER_US,
  parameter int unsigned OFS_CYC  = `MARS_OFS_DELAY_US * `MARS_CYC_PER_US,
  parameter int unsigned BIAS_CYC = `MARS_BIAS_DELAY_US * `MARS_CYC_PER_US,
  parameter int unsigned DOWN_CYC = `MARS_DOWN_STEP_US * `MARS_CYC_PER_US
)
(
  // Clock and reset.
  input  wire logic       CLOCK,
  input  wire logic       RESET_N,
  // Power request from the host.
  input  wire logic       POWER_REQUEST_IN,
  // Rail fault reports, one per rail, and the per-fault interrupt mask.
  input  wire logic [2:0] RAIL_FAULT_IN,
  input  wire logic [2:0] FAULT_MASK_IN,
  // Rail enables and array initialisation.
  output mars_rails_type  RAIL_ENABLE,
  output mars_rails_type  RAIL_DISCHARGE,
  output logic            ARRAY_INIT,
  // Load release for the LED driver and colour-strobe decoder.
  output logic            LED_STROBE_ENABLE,
  // Interrupt, active low.
  output logic            INTERRUPT_OUT_N,
  // Status.
  output logic            SEQ_BUSY,
  output logic            FAULT_SHUTDOWN
);

  // Every assertion below watches this one clock and idles in reset.
  default clocking seq_cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic                 req_meta_r;   // First stage, read only by second.
  logic                 req_sync_r;   // Synchronised power request.
  logic [2:0]           flt_meta_r;   // First stage for faults.
  logic [2:0]           flt_sync_r;   // Synchronised rail faults.
  logic [2:0]           msk_meta_r;   // First stage for mask.
  logic [2:0]           msk_sync_r;   // Synchronised mask.

  // Two flops on every asynchronous input before any logic reads it.
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      req_meta_r <= 1'b0;
      req_sync_r <= 1'b0;
      flt_meta_r <= 3'h0;
      flt_sync_r <= 3'h0;
      msk_meta_r <= 3'h0;
      msk_sync_r <= 3'h0;
    end
    else
    begin
      req_meta_r <= POWER_REQUEST_IN;
      req_sync_r <= req_meta_r;
      flt_meta_r <= RAIL_FAULT_IN;
      flt_sync_r <= flt_meta_r;
      msk_meta_r <= FAULT_MASK_IN;
      msk_sync_r <= msk_meta_r;
    end
  end

  // ****************************************************************
  // Request deglitch
  // ****************************************************************
  logic                 req_r;        // Filtered power request.
  logic [`MARS_DGL_W-1:0] dgl_cnt_r;  // Cycles the new level has held.

  // A change is accepted only after it has held for the whole filter
  // time; any bounce restarts the count, so short glitches vanish.
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      req_r     <= 1'b0;
      dgl_cnt_r <= '0;
    end
    else if (req_sync_r == req_r)
    begin
      dgl_cnt_r <= '0;
    end
    else if (dgl_cnt_r >= `MARS_DGL_W'(DGL_CYC - 1)) // RQ6
    begin
      req_r     <= req_sync_r;
      dgl_cnt_r <= '0;
    end
    else
    begin
      dgl_cnt_r <= dgl_cnt_r + 1'b1;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  mars_state_type         state_r;    // Current state.
  logic [`MARS_CNT_W-1:0] cnt_r;      // Delay counter within a state.
  logic                   any_fault;  // Any rail reports a fault.
  logic                   cnt_done;   // Selected delay has elapsed.
  logic [`MARS_CNT_W-1:0] cnt_limit;  // Delay for the current state.

  assign any_fault = |flt_sync_r;

  // Each timed state waits its delay; both power-down states share DOWN_CYC.
  always_comb
  begin
    case (state_r)
      MARS_INIT:    cnt_limit = `MARS_CNT_W'(OFS_CYC);
      MARS_OFS_ON:  cnt_limit = `MARS_CNT_W'(BIAS_CYC);
      default:      cnt_limit = `MARS_CNT_W'(DOWN_CYC);
    endcase
  end

  assign cnt_done = (cnt_r >= cnt_limit - 1'b1);

  // Fault has priority over everything; a dropped request aborts a
  // power-up part way and walks down in order. The fault state is left
  // only once faults clear and the request is low, so a short on a rail
  // cannot make the sequencer retry into it endlessly.
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      state_r <= MARS_OFF;
      cnt_r   <= '0;
    end
    else if (any_fault && state_r != MARS_OFF && state_r != MARS_FAULT)
    begin
      state_r <= MARS_FAULT; // RQ5
      cnt_r   <= '0;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
      case (state_r)
        MARS_OFF:
        begin
          cnt_r <= '0;
          if (req_r && !any_fault)
            state_r <= MARS_INIT; // RQ1
        end
        MARS_INIT:
        begin
          if (!req_r)
          begin
            state_r <= MARS_DN_RAIL; // RQ8
            cnt_r   <= '0;
          end
          else if (cnt_done)
          begin
            state_r <= MARS_OFS_ON; // RQ1
            cnt_r   <= '0;
          end
        end
        MARS_OFS_ON:
        begin
          if (!req_r)
          begin
            state_r <= MARS_DN_RAIL; // RQ8
            cnt_r   <= '0;
          end
          else if (cnt_done)
          begin
            state_r <= MARS_ALL_ON; // RQ2
            cnt_r   <= '0;
          end
        end
        MARS_ALL_ON:
        begin
          cnt_r <= '0;
          if (!req_r)
            state_r <= MARS_DN_LOAD; // RQ4
        end
        MARS_DN_LOAD:
        begin
          // Load, bias and reset rails are off; the offset rail stays
          // up for one more step so it still drops last.
          if (cnt_done)
          begin
            state_r <= MARS_DN_RAIL; // RQ4
            cnt_r   <= '0;
          end
        end
        MARS_DN_RAIL:
        begin
          // Every rail is off; wait a further step for the discharge
          // before a new power-up may start.
          if (cnt_done)
          begin
            state_r <= MARS_OFF; // RQ4
            cnt_r   <= '0;
          end
        end
        MARS_FAULT:
        begin
          cnt_r <= '0;
          if (!any_fault && !req_r)
            state_r <= MARS_OFF;
        end
        default:
        begin
          state_r <= MARS_OFF;
          cnt_r   <= '0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Registered outputs derived from the current state, one cycle behind it; the load release rises a cycle after the rails.
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      RAIL_ENABLE       <= '0;
      RAIL_DISCHARGE    <= '{1'b1, 1'b1, 1'b1};
      ARRAY_INIT        <= 1'b0;
      LED_STROBE_ENABLE <= 1'b0;
      SEQ_BUSY          <= 1'b0;
      FAULT_SHUTDOWN    <= 1'b0;
    end
    else
    begin
      RAIL_ENABLE.offset_rail <= (state_r == MARS_OFS_ON) ||
                                 (state_r == MARS_ALL_ON) ||
                                 (state_r == MARS_DN_LOAD); // RQ1
      RAIL_ENABLE.bias_rail        <= (state_r == MARS_ALL_ON); // RQ2
      RAIL_ENABLE.array_reset_rail <= (state_r == MARS_ALL_ON); // RQ2
      // Each rail discharges whenever it is not enabled, so the fault
      // state, which enables nothing, discharges all three together.
      RAIL_DISCHARGE.offset_rail <= !((state_r == MARS_OFS_ON) ||
                                      (state_r == MARS_ALL_ON) ||
                                      (state_r == MARS_DN_LOAD)); // RQ5
      RAIL_DISCHARGE.bias_rail        <= (state_r != MARS_ALL_ON); // RQ5
      RAIL_DISCHARGE.array_reset_rail <= (state_r != MARS_ALL_ON); // RQ5
      ARRAY_INIT <= (state_r == MARS_INIT); // RQ1
      // Load release only with all three rails already on.
      LED_STROBE_ENABLE <= (state_r == MARS_ALL_ON) &&
                           RAIL_ENABLE.offset_rail &&
                           RAIL_ENABLE.bias_rail &&
                           RAIL_ENABLE.array_reset_rail; // RQ3
      SEQ_BUSY       <= (state_r != MARS_OFF) && (state_r != MARS_ALL_ON);
      FAULT_SHUTDOWN <= (state_r == MARS_FAULT);
    end
  end

  // Interrupt low while an unmasked fault is reported; the mask never
  // changes the shutdown path above.
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      INTERRUPT_OUT_N <= 1'b1;
    else
      INTERRUPT_OUT_N <= !(|(flt_sync_r & ~msk_sync_r)); // RQ7
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_LOAD_AFTER_RAILS: assert property // RQ3
    (LED_STROBE_ENABLE |-> RAIL_ENABLE == 3'h7)
    else $error("LED enable without all rails on.");

  AST_FAULT_ALL_OFF: assert property // RQ5
    (state_r == MARS_FAULT |=> RAIL_ENABLE == 3'h0 &&
      RAIL_DISCHARGE == 3'h7)
    else $error("Fault did not discharge all rails.");

  AST_FAULT_ENTRY: assert property // RQ5
    ((any_fault && state_r == MARS_ALL_ON) |=> state_r == MARS_FAULT)
    else $error("Fault did not force fast shutdown.");

  AST_INT_UNMASKED: assert property // RQ7
    (|(flt_sync_r & ~msk_sync_r) |=> !INTERRUPT_OUT_N)
    else $error("Unmasked fault did not pull interrupt low.");

  AST_INT_MASKED: assert property // RQ7
    ((flt_sync_r & ~msk_sync_r) == 3'h0 |=> INTERRUPT_OUT_N)
    else $error("Interrupt low without an unmasked fault.");

  AST_BIAS_AFTER_OFS: assert property // RQ2
    ($rose(RAIL_ENABLE.bias_rail) |-> RAIL_ENABLE.offset_rail &&
      $past(RAIL_ENABLE.offset_rail))
    else $error("Bias rail rose before offset rail.");

  AST_OFS_AFTER_INIT: assert property // RQ1
    ($rose(RAIL_ENABLE.offset_rail) |-> $past(ARRAY_INIT))
    else $error("Offset rail rose without array initialisation.");

  AST_ABORT_UP: assert property // RQ8
    ((!req_r && !any_fault && (state_r == MARS_INIT ||
      state_r == MARS_OFS_ON)) |=> state_r == MARS_DN_RAIL)
    else $error("Request drop did not abort power-up.");

  AST_ORDERED_DOWN: assert property // RQ4
    ((!req_r && !any_fault && state_r == MARS_ALL_ON)
      |=> state_r == MARS_DN_LOAD)
    else $error("Request drop did not start ordered power-down.");

  // The filtered level may only move once the full filter time ran out.
  AST_DEGLITCH: assert property // RQ6
    ($changed(req_r) |-> $past(req_sync_r) != $past(req_r) &&
      $past(dgl_cnt_r) == `MARS_DGL_W'(DGL_CYC - 1))
    else $error("Filtered request changed before the filter time.");

endmodule : mars_sequencer

// *** mars_rail_model.sv ***
// Purpose: Model of the three array rails seen by the sequencer.
// Assumes: A rail reports a fault only once a short meets power.
// Notes:   A seen short latches until the bench lifts the command.
module mars_rail_model
  import mars_pkg::*;
(
  // Clock.
  input  wire logic       clock,
  // Rail enables from the sequencer and the bench's short command.
  input  mars_rails_type  rail_en,
  input  wire logic [2:0] short_cmd,
  // Fault reports, msb is the offset rail.
  output logic [2:0]      fault
);
  // ****************************************************************
  // Fault reporting
  // ****************************************************************
  // An unpowered rail cannot show a short, but once seen the fault
  // holds after discharge, as a real short keeps the supply tripped.
  always_ff @(posedge clock)
  begin
    fault <= short_cmd & (rail_en | fault);
  end
endmodule : mars_rail_model

// *** tb.sv ***
// Purpose: Self-checking bench for the rail sequencer.
// Assumes: Shortened delays through the sequencer's parameters.
// Notes:   Every scenario judges its own outcome before returning.
module tb
  import mars_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Shortened counts handed to the sequencer.
  localparam int OFS  = 5;
  localparam int BIAS = 8;
  localparam int DOWN = 3;
  logic           clock;     // Bench clock, 40 ns period.
  logic           reset_n;   // Synchronous reset, active low.
  logic           req;       // Power request.
  logic [2:0]     mask;      // Interrupt mask per fault.
  logic [2:0]     short_cmd; // Short injected into the rails.
  logic [2:0]     fault;     // Fault reports from the rail model.
  mars_rails_type en;        // Rail enables.
  mars_rails_type dis;       // Rail discharges.
  logic           init;      // Array initialisation.
  logic           led;       // Load release.
  logic           int_n;     // Interrupt, active low.
  logic           busy;      // Sequencing in progress.
  logic           fshut;     // Fault shutdown state.
  int             failures;  // Mismatches seen.
  int             cmp_count; // Comparisons made.
  int             cycles;    // Cycles run, for the hang guard.

  mars_sequencer #(.DGL_CYC(4), .OFS_CYC(OFS), .BIAS_CYC(BIAS),
    .DOWN_CYC(DOWN)) i_dut (.CLOCK(clock), .RESET_N(reset_n),
    .POWER_REQUEST_IN(req), .RAIL_FAULT_IN(fault),
    .FAULT_MASK_IN(mask), .RAIL_ENABLE(en), .RAIL_DISCHARGE(dis),
    .ARRAY_INIT(init), .LED_STROBE_ENABLE(led),
    .INTERRUPT_OUT_N(int_n), .SEQ_BUSY(busy), .FAULT_SHUTDOWN(fshut));
  mars_rail_model i_rails (.clock(clock), .rail_en(en),
    .short_cmd(short_cmd), .fault(fault));

  // Clock generation.
  always #20 clock = ~clock;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Compares and reports one value.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask : check

  // Lets an edge pass and its updates settle.
  task tick;
    @(posedge clock);
    #1;
  endtask : tick

  // Prints the verdict and stops.
  task end_sim;
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // A request pulse shorter than the filter must start nothing.
  task t_glitch;
    @(posedge clock);
    req <= 1'b1;
    repeat (2) @(posedge clock);
    req <= 1'b0;
    repeat (20) tick;
    check({busy, init, en}, 5'h00);
  endtask : t_glitch

  // Full power-up with measured delays and load release.
  task t_power_up;
    int n;
    n = 0;
    @(posedge clock);
    req <= 1'b1;
    while (init !== 1'b1 && n < 40)
    begin
      tick;
      n++;
    end
    check(en, 3'h0);
    n = 0;
    while (en.offset_rail !== 1'b1 && n < 40)
    begin
      tick;
      n++;
    end
    check(n, OFS);
    check(init, 1'b0);
    n = 0;
    while (en.bias_rail !== 1'b1 && n < 40)
    begin
      check(led, 1'b0);
      tick;
      n++;
    end
    check(n, BIAS);
    check(en, 3'h7);
    tick;
    check(led, 1'b1);
  endtask : t_power_up

  // Ordered power-down: load together with bias and reset, then offset.
  task t_power_down;
    int n;
    n = 0;
    @(posedge clock);
    req <= 1'b0;
    while (en.bias_rail !== 1'b0 && n < 40)
    begin
      tick;
      n++;
    end
    check({led, en}, 4'h4);
    n = 0;
    while (en.offset_rail !== 1'b0 && n < 40)
    begin
      tick;
      n++;
    end
    check(n, DOWN);
    n = 0;
    while (busy !== 1'b0 && n < 40)
    begin
      tick;
      n++;
    end
    check(n, DOWN);
    check({en, dis}, 6'h07);
  endtask : t_power_down

  // A request dropped before the bias and reset rails are up aborts.
  task t_abort;
    @(posedge clock);
    req <= 1'b1;
    while (init !== 1'b1)
      tick;
    @(posedge clock);
    req <= 1'b0;
    repeat (40)
    begin
      tick;
      check(en.bias_rail | led, 1'b0);
    end
    check({busy, en, dis}, 7'h07);
  endtask : t_abort

  // A bias short drops all rails at once; the mask gates the interrupt.
  task t_fault(input logic [2:0] m, input logic exp_int_n);
    int n;
    n = 0;
    @(posedge clock);
    mask <= m;
    t_power_up;
    @(posedge clock);
    short_cmd <= 3'h2;
    while (en === 3'h7 && n < 10)
    begin
      tick;
      n++;
    end
    check({en, dis, led, fshut}, 8'h1D);
    check(int_n, exp_int_n);
    @(posedge clock);
    short_cmd <= 3'h0;
    req <= 1'b0;
    repeat (30) tick;
    check({fshut, busy, int_n}, 3'h1);
  endtask : t_fault

  // ****************************************************************
  // Main sequence and hang guard
  // ****************************************************************
  // Cuts a hung run short.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      end_sim;
    end
  end

  // Reset, then every scenario in turn.
  initial
  begin
    clock = 1'b0;
    reset_n = 1'b0;
    req = 1'b0;
    mask = 3'h0;
    short_cmd = 3'h0;
    failures = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (20) @(posedge clock);
    #1;
    check({en, dis, int_n}, 7'h0F);
    @(posedge clock);
    reset_n <= 1'b1;
    t_glitch;
    t_power_up;
    t_power_down;
    t_abort;
    t_fault(3'h5, 1'b0);
    t_fault(3'h2, 1'b1);
    end_sim;
  end
endmodule : tb
